// [verification/pipc_master_model.sv]
// Two-wire bus master model standing in for the system controller.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module pipc_master_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Data changes only while the bus clock is low.
  task automatic bit_io(input logic b, output logic s);
    scl = 1'b0;
    tick(2);
    sda_low = ~b;
    tick(2);
    scl = 1'b1;
    tick(2);
    s = sda_line;
    tick(1);
  endtask

  // Sends start, bytes MSB first and stop; the frame ends early after the
  // first unacknowledged byte, whose index is returned, or -1.
  task automatic send(input logic [7:0] q[$], output int nack_at);
    logic s;
    nack_at = -1;
    tick(2);
    sda_low = 1'b1;
    tick(2);
    foreach (q[i]) begin
      if (nack_at < 0) begin
        for (int k = 7; k >= 0; k--) bit_io(q[i][k], s);
        bit_io(1'b1, s);
        if (s) nack_at = i;
      end
    end
    scl = 1'b0;
    tick(2);
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(2);
    sda_low = 1'b0;
    tick(2);
  endtask
endmodule
`default_nettype wire

// [verification/test_pipc_ctrl.sv]
// Self-checking bench for the inset picture control register group.
// Assumes the design files and the bus master model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_pipc_ctrl;
  logic                 clk = 1'b0;
  logic                 rstn = 1'b0;
  logic [1:0]           addr_strap = 2'h0;
  logic [1:0]           hpos_msb = 2'h3;
  logic                 idet = 1'b0;
  logic                 pdet = 1'b0;
  logic                 scl, sda_low, sda_o, sda_oe, i625, p625;
  logic                 a_o, a_oe, b_o, b_oe;
  pipc_pkg::pipc_ctrl_s ctrl;
  logic [7:0]           img [2:8];
  logic [7:0]           dev = 8'hD6;
  logic                 sticky = 1'b0;
  int                   n_errors = 0;
  int                   checks = 0;
  wire                  sda_line = !(sda_low || (sda_oe && !sda_o));

  always #5 clk = ~clk;

  pipc_ctrl pipc_ctrl_inst (.clk(clk), .rstn(rstn), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_strap(addr_strap), .inset_hpos_msb(hpos_msb),
    .inset_detect_625(idet), .parent_detect_625(pdet),
    .inset_is_625(i625), .parent_is_625(p625), .switch_out_a_o(a_o),
    .switch_out_a_oe(a_oe), .switch_out_b_o(b_o),
    .switch_out_b_oe(b_oe), .ctrl(ctrl));
  pipc_master_model pipc_master_model_inst (.clk(clk),
    .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  // ----------------------------------------------------------------
  // Expectations and shared checks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [1:0] pin(input logic [1:0] c);
    return (c == 2'h0) ? 2'h2 : ((c == 2'h1) ? 2'h0 : 2'h3);
  endfunction

  function automatic pipc_pkg::pipc_ctrl_s expc();
    pipc_pkg::pipc_ctrl_s c;
    c.inset_horiz_position = {hpos_msb, img[2]};
    c.inset_vert_position = img[3];
    c.luma_input_delay = img[4][2:0];
    c.chroma_input_invert = img[5][4];
    c.inset_sync_source = img[5][5];
    c.horiz_decimation_ratio = img[5][6] ? 3'h4 : 3'h3;
    c.vert_decimation_ratio = img[5][7] ? 3'h4 : 3'h3;
    c.inset_hsync_delay_clks = 7'(img[6][3:0] * 4'h6);
    c.inset_clock_source = sticky;
    c.clamp_delay_clks = img[6][5] ? 7'h00 :
                         c.inset_hsync_delay_clks;
    c.clamp_cycle_count = img[6][6] ? 2'h2 : 2'h3;
    c.inset_vsync_delay = img[7][4:0];
    c.inset_vsync_noise_reduce = img[7][5];
    c.decimation_gain_double = img[7][7];
    c.parent_vsync_delay = img[8][4:0];
    c.parent_vsync_noise_reduce = img[8][5];
    c.double_rate_sync_source = img[8][7] & img[5][5];
    return c;
  endfunction

  task automatic chk_all();
    chk({4'h0, ctrl}, {4'h0, expc()});
    chk({a_oe, a_oe & a_o, b_oe, b_oe & b_o},
        {pin(img[4][4:3]), pin(img[4][6:5])});
    chk(sda_oe, 1'b0);
  endtask

  // Writes a frame; only the strapped address is acknowledged.
  task automatic wr(input logic [7:0] a, input logic [7:0] sub,
                    input logic [7:0] d[$]);
    int         na;
    logic [7:0] s;
    mst_send(a, sub, d, na);
    chk(na >= 0, a != dev);
    if (a == dev) begin
      foreach (d[i]) begin
        s = 8'(sub + i);
        if (s >= 8'h02 && s <= 8'h08) img[s[3:0]] = d[i];
        if (s == 8'h06 && d[i][4]) sticky = 1'b1;
      end
    end
    chk_all();
  endtask

  task automatic mst_send(input logic [7:0] a, input logic [7:0] sub,
                          input logic [7:0] d[$], output int na);
    logic [7:0] q[$];
    q = d;
    q.push_front(sub);
    q.push_front(a);
    pipc_master_model_inst.send(q, na);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_burst();
    hpos_msb = 2'h2;
    wr(dev, 8'h02, '{8'hE4, 8'hDC, 8'h7F, 8'hF0,
                     8'h4F, 8'hBF, 8'h9F});
    hpos_msb = 2'h0;
    wr(dev, 8'h02, '{8'h02});
    wr(dev, 8'h05, '{8'h00, 8'h35, 8'h80});
    wr(dev, 8'h08, '{8'h80});
    wr(dev, 8'h06, '{8'h01});
    for (int c = 0; c < 4; c++) begin
      wr(dev, 8'h04, '{8'(c * 8 + (3 - c) * 32)});
    end
  endtask

  task automatic t_std();
    logic [1:0] ic [5] = '{2'h0, 2'h0, 2'h3, 2'h1, 2'h2};
    logic [1:0] pc [5] = '{2'h0, 2'h0, 2'h0, 2'h3, 2'h2};
    logic [4:0] det = 5'b01010;
    logic [4:0] ei = 5'b01010;
    logic [4:0] ep = 5'b01010;
    for (int i = 0; i < 5; i++) begin
      idet = det[4 - i];
      pdet = det[4 - i];
      wr(dev, 8'h05, '{{4'h0, pc[i], ic[i]}});
      repeat (3) @(negedge clk);
      chk({i625, p625}, {ei[4 - i], ep[4 - i]});
      // A held standard must ignore a detector that moves on.
      if (ic[i] == 2'h3) idet = ~idet;
      if (pc[i] == 2'h3) pdet = ~pdet;
      repeat (3) @(negedge clk);
      chk({i625, p625}, {ei[4 - i], ep[4 - i]});
    end
  endtask

  task automatic t_reset();
    @(negedge clk);
    rstn = 1'b0;
    foreach (img[i]) img[i] = 8'h00;
    sticky = 1'b0;
    repeat (2) @(negedge clk);
    chk_all();
    chk({i625, p625}, 2'h3);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    wr(dev, 8'h03, '{8'h5A});
  endtask

  task automatic t_refuse();
    for (int s = 3; s >= 0; s--) begin
      addr_strap = 2'(s);
      dev = (s == 0) ? 8'hD6 : ((s == 1) ? 8'hDC : 8'hDE);
      wr(8'hD6, 8'h03, '{8'h11});
      wr(8'hDC, 8'h03, '{8'h22});
      wr(8'hDE, 8'h03, '{8'h33});
      wr(dev | 8'h01, 8'h03, '{8'h44});
    end
    wr(dev, 8'h08, '{8'h25, 8'hFF});
    wr(dev, 8'h01, '{8'hFF, 8'h11});
  endtask

  task automatic summarize();
    $display("checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    foreach (img[i]) img[i] = 8'h00;
    repeat (6) @(negedge clk);
    chk_all();
    chk({i625, p625}, 2'h3);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    t_burst();
    t_std();
    t_refuse();
    t_reset();
    summarize();
  end

  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire

// [verilog/pipc_ctrl.sv]
// Write-only two-wire slave and control register group, subaddresses 02-08.
// Assumes scl and sda are already synchronous to clk and that the high bits
// of the horizontal position arrive from the neighbouring register group.
//
// Notes on behaviour
// - Horizontal position low byte, one pixel steps
// - Vertical position byte, one line steps
// - Three-bit luma delay, 000 least, 111 most
// - Switch fields drive three-level pins
// - Inset standard: auto, 625, 525, hold
// - Parent standard uses same four codes
// - Chroma invert bit negates both chroma inputs
// - Sync source: separate pins or sand-castle
// - Decimation bits select 3:1 or 4:1
// - Hsync delay steps of six clocks
// - Clock source bit sticks once set
// - Clamp fix decouples clamp from hsync delay
// - Clamp count bit: three or two cycles
// - Inset vsync delay in 2.37 us steps
// - Gain bit doubles decimation filter gain
// - Parent vsync delay, 2.37 or 1.68 us
// - Double-rate sync source needs sand-castle inset
// - Power-up clears every register byte
`timescale 1ns/10ps
`default_nettype none
`include "pipc_regs.svh"

module pipc_ctrl (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe,
  input  wire logic [1:0]         addr_strap,
  input  wire logic [1:0]         inset_hpos_msb,
  input  wire logic               inset_detect_625,
  input  wire logic               parent_detect_625,
  output logic                    inset_is_625,
  output logic                    parent_is_625,
  output logic                    switch_out_a_o,
  output logic                    switch_out_a_oe,
  output logic                    switch_out_b_o,
  output logic                    switch_out_b_oe,
  output pipc_pkg::pipc_ctrl_s    ctrl
);

  // ---------------------------------------------------------------------
  // Two-wire bus condition detection
  // ---------------------------------------------------------------------
  logic                 scl_q;
  logic                 sda_q;
  pipc_pkg::pipc_state_e state_q;
  logic [3:0]           bitcnt_q;
  logic [7:0]           shift_q;
  logic [7:0]           sub_q;
  pipc_pkg::pipc_state_e after_ack_q;
  logic [7:0]           dev_addr;
  logic                 start_cond;
  logic                 stop_cond;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 byte_done;
  logic                 data_wr;

  assign start_cond = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_cond  = scl_i & scl_q & ~sda_q & sda_i;
  assign scl_rise   = scl_i & ~scl_q;
  assign scl_fall   = ~scl_i & scl_q;
  assign byte_done  = scl_fall & (bitcnt_q == 4'h8);
  assign dev_addr   = (addr_strap == 2'h0) ? `PIPC_ADDR_LOW :
                      (addr_strap == 2'h1) ? `PIPC_ADDR_MID : `PIPC_ADDR_HIGH;
  assign data_wr    = byte_done & (state_q == pipc_pkg::ST_DATA);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // ---------------------------------------------------------------------
  // Receiver: address, subaddress, then data bytes with auto-increment
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q     <= pipc_pkg::ST_IDLE;
      after_ack_q <= pipc_pkg::ST_SUB;
      bitcnt_q    <= 4'h0;
      shift_q     <= 8'h00;
      sub_q       <= 8'h00;
    end else if (stop_cond) begin
      state_q <= pipc_pkg::ST_IDLE;
    end else if (start_cond) begin
      state_q  <= pipc_pkg::ST_ADDR;
      bitcnt_q <= 4'h0;
    end else begin
      unique case (state_q)
        pipc_pkg::ST_IDLE, pipc_pkg::ST_SKIP: begin
        end
        pipc_pkg::ST_ADDR, pipc_pkg::ST_SUB, pipc_pkg::ST_DATA: begin
          if (scl_rise && bitcnt_q != 4'h8) begin
            shift_q  <= {shift_q[6:0], sda_i};
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (byte_done) begin
            bitcnt_q <= 4'h0;
            state_q  <= pipc_pkg::ST_ACK;
            if (state_q == pipc_pkg::ST_ADDR) begin
              // Only the write form of our address is answered.
              if (shift_q != dev_addr) begin
                state_q <= pipc_pkg::ST_SKIP;
              end
              after_ack_q <= pipc_pkg::ST_SUB;
            end else if (state_q == pipc_pkg::ST_SUB) begin
              sub_q       <= shift_q;
              after_ack_q <= pipc_pkg::ST_DATA;
            end else begin
              sub_q       <= sub_q + 8'h01;
              after_ack_q <= pipc_pkg::ST_DATA;
            end
          end
        end
        pipc_pkg::ST_ACK: begin
          if (scl_fall) begin
            state_q <= after_ack_q;
          end
        end
      endcase
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = (state_q == pipc_pkg::ST_ACK);

  // ---------------------------------------------------------------------
  // Register bytes
  // ---------------------------------------------------------------------
  logic [7:0] hpos_low_q;
  logic [7:0] vpos_q;
  logic [7:0] luma_sw_q;
  logic [7:0] std_dec_q;
  logic [7:0] hsync_clamp_q;
  logic [7:0] vsync_gain_q;
  logic [7:0] parent_vsync_q;
  logic [7:0] hsync_clamp_d;

  // The clock source bit can be set but is cleared again only by reset.
  assign hsync_clamp_d = {shift_q[7:5],
                          shift_q[`PIPC_CLK_SRC_BIT] |
                            hsync_clamp_q[`PIPC_CLK_SRC_BIT],
                          shift_q[3:0]};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hpos_low_q     <= `PIPC_REG_RESET;
      vpos_q         <= `PIPC_REG_RESET;
      luma_sw_q      <= `PIPC_REG_RESET;
      std_dec_q      <= `PIPC_REG_RESET;
      hsync_clamp_q  <= `PIPC_REG_RESET;
      vsync_gain_q   <= `PIPC_REG_RESET;
      parent_vsync_q <= `PIPC_REG_RESET;
    end else if (data_wr) begin
      unique case (sub_q)
        `PIPC_SUB_HPOS_LOW:     hpos_low_q     <= shift_q;
        `PIPC_SUB_VPOS:         vpos_q         <= shift_q;
        `PIPC_SUB_LUMA_SW:      luma_sw_q      <= shift_q;
        `PIPC_SUB_STD_DEC:      std_dec_q      <= shift_q;
        `PIPC_SUB_HSYNC_CLAMP:  hsync_clamp_q  <= hsync_clamp_d;
        `PIPC_SUB_VSYNC_GAIN:   vsync_gain_q   <= shift_q;
        `PIPC_SUB_PARENT_VSYNC: parent_vsync_q <= shift_q;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Line standard selection with hold of the last output value
  // ---------------------------------------------------------------------
  function automatic logic std_pick(input logic [1:0] mode,
                                    input logic       detect,
                                    input logic       held);
    unique case (mode)
      pipc_pkg::STD_AUTO:  std_pick = detect;
      pipc_pkg::STD_625:   std_pick = 1'b1;
      pipc_pkg::STD_525:   std_pick = 1'b0;
      default:             std_pick = held;
    endcase
  endfunction

  logic [1:0] inset_standard_select;
  logic [1:0] parent_standard_select;
  logic       inset_625_d;
  logic       parent_625_d;

  assign inset_standard_select         = std_dec_q[`PIPC_INSET_STANDARD_SELECT_LSB +: 2];
  assign parent_standard_select         = std_dec_q[`PIPC_PARENT_STANDARD_SELECT_LSB +: 2];
  assign inset_625_d  = std_pick(inset_standard_select, inset_detect_625, inset_is_625);
  assign parent_625_d = std_pick(parent_standard_select, parent_detect_625, parent_is_625);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      inset_is_625  <= 1'b1;
      parent_is_625 <= 1'b1;
    end else begin
      inset_is_625  <= inset_625_d;
      parent_is_625 <= parent_625_d;
    end
  end

  // ---------------------------------------------------------------------
  // Three-level switch pins: mid level is the pin left open
  // ---------------------------------------------------------------------
  logic [1:0] sw_a;
  logic [1:0] sw_b;

  assign sw_a            = luma_sw_q[`PIPC_SW_A_LSB +: 2];
  assign sw_b            = luma_sw_q[`PIPC_SW_B_LSB +: 2];
  assign switch_out_a_o  = sw_a[1];
  assign switch_out_a_oe = (sw_a != 2'h1);
  assign switch_out_b_o  = sw_b[1];
  assign switch_out_b_oe = (sw_b != 2'h1);

  // ---------------------------------------------------------------------
  // Decoded controls
  // ---------------------------------------------------------------------
  logic [6:0] hsdel_clks;

  assign hsdel_clks = 7'(hsync_clamp_q[`PIPC_HSDEL_LSB +: 4]) *
                      `PIPC_HSDEL_STEP_CLKS;

  always_comb begin
    ctrl = '0;
    ctrl.inset_horiz_position = {inset_hpos_msb, hpos_low_q};
    ctrl.inset_vert_position  = vpos_q;
    ctrl.luma_input_delay     = luma_sw_q[`PIPC_LUMA_DEL_LSB +: 3];
    ctrl.chroma_input_invert  = std_dec_q[`PIPC_CHR_INV_BIT];
    ctrl.inset_sync_source    = std_dec_q[`PIPC_SYNC_SRC_BIT];
    ctrl.horiz_decimation_ratio = std_dec_q[`PIPC_HDEC_BIT] ?
      `PIPC_DEC_RATIO_HIGH : `PIPC_DEC_RATIO_LOW;
    ctrl.vert_decimation_ratio  = std_dec_q[`PIPC_VDEC_BIT] ?
      `PIPC_DEC_RATIO_HIGH : `PIPC_DEC_RATIO_LOW;
    ctrl.inset_hsync_delay_clks = hsdel_clks;
    ctrl.inset_clock_source   = hsync_clamp_q[`PIPC_CLK_SRC_BIT];
    ctrl.clamp_delay_clks     = hsync_clamp_q[`PIPC_CLAMP_FIX_BIT] ?
      7'h00 : hsdel_clks;
    ctrl.clamp_cycle_count    = hsync_clamp_q[`PIPC_CLAMP_CNT_BIT] ?
      `PIPC_CLAMP_CYC_2 : `PIPC_CLAMP_CYC_3;
    ctrl.inset_vsync_delay    = vsync_gain_q[`PIPC_VSDEL_LSB +: 5];
    ctrl.inset_vsync_noise_reduce = vsync_gain_q[`PIPC_VS_NR_BIT];
    ctrl.decimation_gain_double   = vsync_gain_q[`PIPC_GAIN_BIT];
    ctrl.parent_vsync_delay = parent_vsync_q[`PIPC_VSDEL_LSB +: 5];
    ctrl.parent_vsync_noise_reduce = parent_vsync_q[`PIPC_VS_NR_BIT];
    // Shared pins are only taken while the inset uses the sand-castle pin.
    ctrl.double_rate_sync_source = parent_vsync_q[`PIPC_DR_SRC_BIT] &
                                   std_dec_q[`PIPC_SYNC_SRC_BIT];
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_clk_src_sticky: assert property (
    $past(ctrl.inset_clock_source) |-> ctrl.inset_clock_source)
    else $error("inset clock source returned to zero");
  a_hpos_write: assert property (
    data_wr && sub_q == `PIPC_SUB_HPOS_LOW |=>
      ctrl.inset_horiz_position[7:0] == $past(shift_q))
    else $error("horizontal position low byte not stored");
  a_sub_increment: assert property (
    data_wr && !stop_cond && !start_cond |=> sub_q == $past(sub_q) + 8'h01)
    else $error("subaddress did not advance after data byte");
  a_ack_one_bit: assert property (
    sda_oe && scl_fall |=> !sda_oe)
    else $error("acknowledge held past its bus clock");
  a_ack_after_byte: assert property (
    $rose(sda_oe) |-> $past(byte_done))
    else $error("acknowledge without a received byte");
  a_switch_mid_open: assert property (
    sw_a == 2'h1 |-> !switch_out_a_oe)
    else $error("switch pin driven at mid level");
  a_switch_high: assert property (
    sw_b[1] |-> switch_out_b_oe && switch_out_b_o)
    else $error("switch pin not high for codes 10 and 11");
  a_std_hold: assert property (
    inset_standard_select == 2'h3 ##1 inset_standard_select == 2'h3 |-> $stable(inset_is_625))
    else $error("inset standard changed while held");
  a_std_fixed: assert property (
    parent_standard_select == 2'h2 |=> !parent_is_625)
    else $error("parent fixed 525 not applied");
  a_clamp_follow: assert property (
    !hsync_clamp_q[`PIPC_CLAMP_FIX_BIT] |->
      ctrl.clamp_delay_clks == 7'(hsync_clamp_q[3:0]) * 7'h06)
    else $error("clamp delay does not track hsync delay");
  a_dr_source: assert property (
    !std_dec_q[`PIPC_SYNC_SRC_BIT] |-> !ctrl.double_rate_sync_source)
    else $error("shared sync pins used without sand-castle inset");

endmodule
`default_nettype wire

// [verilog/pipc_pkg.sv]
// Types shared by the inset picture control register group.
// Assumes pipc_regs.svh holds all numeric constants.
`default_nettype none
package pipc_pkg;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_SUB  = 6'h04,
    ST_DATA = 6'h08,
    ST_ACK  = 6'h10,
    ST_SKIP = 6'h20
  } pipc_state_e;

  typedef enum logic [1:0] {
    STD_AUTO  = 2'h0,
    STD_625   = 2'h1,
    STD_525   = 2'h2,
    STD_FREEZE = 2'h3
  } pipc_std_e;

  typedef struct packed {
    logic [9:0] inset_horiz_position;
    logic [7:0] inset_vert_position;
    logic [2:0] luma_input_delay;
    logic       chroma_input_invert;
    logic       inset_sync_source;
    logic [2:0] horiz_decimation_ratio;
    logic [2:0] vert_decimation_ratio;
    logic [6:0] inset_hsync_delay_clks;
    logic       inset_clock_source;
    logic [6:0] clamp_delay_clks;
    logic [1:0] clamp_cycle_count;
    logic [4:0] inset_vsync_delay;
    logic       inset_vsync_noise_reduce;
    logic       decimation_gain_double;
    logic [4:0] parent_vsync_delay;
    logic       parent_vsync_noise_reduce;
    logic       double_rate_sync_source;
  } pipc_ctrl_s;

endpackage
`default_nettype wire

// [verilog/pipc_regs.svh]
// Constants of the inset picture position, sync and control register group.
// Assumes inclusion by the design file of this group.
`ifndef PIPC_REGS_SVH
`define PIPC_REGS_SVH

`define PIPC_SUB_HPOS_LOW      8'h02
`define PIPC_SUB_VPOS          8'h03
`define PIPC_SUB_LUMA_SW       8'h04
`define PIPC_SUB_STD_DEC       8'h05
`define PIPC_SUB_HSYNC_CLAMP   8'h06
`define PIPC_SUB_VSYNC_GAIN    8'h07
`define PIPC_SUB_PARENT_VSYNC  8'h08

`define PIPC_REG_RESET         8'h00

`define PIPC_ADDR_LOW          8'hD6
`define PIPC_ADDR_MID          8'hDC
`define PIPC_ADDR_HIGH         8'hDE

`define PIPC_LUMA_DEL_LSB      0
`define PIPC_SW_A_LSB          3
`define PIPC_SW_B_LSB          5
`define PIPC_INSET_STANDARD_SELECT_LSB          0
`define PIPC_PARENT_STANDARD_SELECT_LSB          2
`define PIPC_CHR_INV_BIT       4
`define PIPC_SYNC_SRC_BIT      5
`define PIPC_HDEC_BIT          6
`define PIPC_VDEC_BIT          7
`define PIPC_HSDEL_LSB         0
`define PIPC_CLK_SRC_BIT       4
`define PIPC_CLAMP_FIX_BIT     5
`define PIPC_CLAMP_CNT_BIT     6
`define PIPC_VSDEL_LSB         0
`define PIPC_VS_NR_BIT         5
`define PIPC_GAIN_BIT          7
`define PIPC_DR_SRC_BIT        7

`define PIPC_HSDEL_STEP_CLKS   7'h06
`define PIPC_VSDEL_STEP_NS_50  2370
`define PIPC_VSDEL_STEP_NS_100 1680
`define PIPC_DEC_RATIO_LOW     3'h3
`define PIPC_DEC_RATIO_HIGH    3'h4
`define PIPC_CLAMP_CYC_3       2'h3
`define PIPC_CLAMP_CYC_2       2'h2

`endif
